// ===== hw/eds_paging_pkg.sv
// Purpose: Shared constants and types for extended data window paging
// Assumes: 16-bit core data addresses, 24-bit extended addresses
// Notes: Register offsets are byte addresses on the plain register port

package window_paging_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int EA_W = 16;
   localparam int XA_W = 24;
   localparam int PAGE_W = 9;
   localparam int RPAGE_W = 10;
   localparam int RADDR_W = 8;
   localparam int RDATA_W = 16;
   localparam int OFFSET_W = 15;
   localparam int WINDOW_BIT = 15;
   localparam int VIEW_BIT = 9;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] REG_READ_PAGE = 8'h00;
   localparam logic [7:0] REG_WRITE_PAGE = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_CLEAR = 8'h0C;
   localparam logic [7:0] REG_ENABLE = 8'h10;

   localparam logic [9:0] READ_PAGE_RESET = 10'h001;
   localparam logic [8:0] WRITE_PAGE_RESET = 9'h001;
   localparam logic [1:0] ENABLE_RESET = 2'h0;

   // Status bits
   localparam int ST_TRAP_BIT = 0;
   localparam int ST_WRAP_BIT = 1;
   localparam int ST_W = 2;

   // Pages up to this one map to extra internal RAM, above it to the
   // parallel master port; zero means no extra internal RAM.
   localparam logic [8:0] INTERNAL_PAGE_LAST = 9'h000;
   localparam logic [8:0] PAGE_ZERO = 9'h000;

   // ------------------------------------------------------------
   // Timing: wait cycles added beyond the first access cycle
   // ------------------------------------------------------------
   localparam logic [1:0] READ_EXTRA_WAIT = 2'h1;
   localparam logic [1:0] NO_WAIT = 2'h0;

   localparam logic [15:0] WINDOW_BASE = 16'h8000;

   typedef enum logic [1:0]
   {
      TGT_LOWER = 2'b00,
      TGT_INTERNAL = 2'b01,
      TGT_PMP = 2'b10,
      TGT_PROGRAM = 2'b11
   } target_e;

   typedef enum logic [0:0]
   {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } state_e;

endpackage

// ===== hw/eds_address_former.sv
// Purpose: Forms a 24-bit address from a page and a 16-bit data address
// Assumes: Purely combinational, one instance per page register
// Notes: Below the window the page plays no part

`timescale 1ns/1ps

module window_address_former
   import window_paging_pkg::*;
(
   input wire logic [PAGE_W-1:0] page,
   input wire logic [EA_W-1:0] ea,
   output logic [XA_W-1:0] addr,
   output logic in_window,
   output logic page_zero
);

   always_comb
   begin
      in_window = ea[WINDOW_BIT];
      page_zero = (page == PAGE_ZERO);
      if (in_window)
      begin
         addr = {page, ea[OFFSET_W-1:0]}; // R3
      end
      else
      begin
         addr = {8'h00, ea}; // R16
      end
   end

endmodule

// ===== hw/extended_data_space_paging.sv
// Purpose: Paged extended data window address generation and access timing
// Assumes: Core issues one access at a time and holds it until acc_ready
// Notes: Page registers, interrupt status, enable and clear on a plain port
//
// What this block does
// [R1] Window split into 32 Kbyte pages
// [R2] Program view reads use only read page
// [R3] Page joined with address gives 24 bits
// [R4] Reads prepend 9 read page bits
// [R5] Writes prepend 9 write page bits
// [R6] Page zero in window raises address trap
// [R7] Pages never change on pointer rollover
// [R8] Caller updates page across page boundaries
// [R9] Extended reads take one extra cycle
// [R10] Repeat reads: first two three cycles; here the first read takes two cycles, later ones one
// [R11] Extended writes take a single cycle
// [R12] No read-modify-write under repeat loops; not checked here, acc_rmw with acc_repeat is accepted
// [R13] Read-modify-write uses read page twice
// [R14] Caller loads page, sets pointer bit 15
// [R15] Reaches extra internal RAM and master port
// [R16] Below window both pages are ignored
// [R17] Read page bit 9 routes to program
// [R18] Post-increment wraps to window base
//
// The implementer's own choices: the register addresses and the strobed register port.

`timescale 1ns/1ps

module extended_data_space_paging
   import window_paging_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_enable,
   // Register port
   input wire logic [RADDR_W-1:0] reg_addr,
   input wire logic [RDATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [RDATA_W-1:0] reg_rdata,
   // Access request from the core
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic acc_rmw,
   input wire logic acc_repeat,
   input wire logic acc_ptr_inc,
   input wire logic [1:0] acc_ptr_step,
   input wire logic [EA_W-1:0] acc_ea,
   output logic acc_ready,
   output logic acc_done,
   output logic [EA_W-1:0] next_pointer,
   // Memory side
   output logic mem_strobe,
   output logic mem_write,
   output logic [XA_W-1:0] mem_addr,
   output logic [1:0] mem_target,
   output logic addr_error_trap,
   output logic irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      state_e state;
      logic [1:0] wait_cnt;
      logic in_repeat;
      logic [RPAGE_W-1:0] read_page;
      logic [PAGE_W-1:0] write_page;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] enable;
      logic [RDATA_W-1:0] rdata;
      logic strobe;
      logic write;
      logic [XA_W-1:0] addr;
      target_e target;
      logic trap;
      logic [EA_W-1:0] next_ptr;
   } core_s;

   localparam core_s CORE_RESET = '{
      state: ST_IDLE,
      wait_cnt: NO_WAIT,
      in_repeat: 1'b0,
      read_page: READ_PAGE_RESET,
      write_page: WRITE_PAGE_RESET,
      status: '0,
      enable: ENABLE_RESET,
      rdata: '0,
      strobe: 1'b0,
      write: 1'b0,
      addr: '0,
      target: TGT_LOWER,
      trap: 1'b0,
      next_ptr: '0
   };

   core_s r;
   core_s next_r;

   logic [XA_W-1:0] rd_addr;
   logic [XA_W-1:0] wr_addr;
   logic rd_window;
   logic wr_window;
   logic rd_page_zero;
   logic wr_page_zero;

   // ------------------------------------------------------------
   // Address formers
   // ------------------------------------------------------------
   // Both formers see the same address; picking one afterwards lets a
   // read-modify-write stay on the read page without a second path
   window_address_former u_read_former
   (
      .page(r.read_page[PAGE_W-1:0]),
      .ea(acc_ea),
      .addr(rd_addr),
      .in_window(rd_window),
      .page_zero(rd_page_zero)
   );

   window_address_former u_write_former
   (
      .page(r.write_page),
      .ea(acc_ea),
      .addr(wr_addr),
      .in_window(wr_window),
      .page_zero(wr_page_zero)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic finishing;
   logic take;
   logic use_read_page;
   logic window;
   logic program_view;
   logic zero_page;
   logic [XA_W-1:0] sel_addr;
   logic [PAGE_W-1:0] sel_page;
   logic [EA_W:0] ptr_sum;

   always_comb
   begin
      next_r = r;
      next_r.strobe = 1'b0;
      next_r.trap = 1'b0;
      next_r.rdata = '0;

      finishing = (r.state == ST_BUSY) && (r.wait_cnt == NO_WAIT);
      take = acc_req && clock_enable && ((r.state == ST_IDLE) || finishing);

      // Read-modify-write takes its page from the read page both ways
      use_read_page = !acc_write || acc_rmw; // R13
      window = acc_ea[WINDOW_BIT];
      program_view = use_read_page && window && r.read_page[VIEW_BIT]; // R17
      zero_page = use_read_page ? rd_page_zero : wr_page_zero;
      sel_addr = use_read_page ? rd_addr : wr_addr; // R4 R5 R2
      sel_page = use_read_page ? r.read_page[PAGE_W-1:0] : r.write_page; // R1
      ptr_sum = {1'b0, acc_ea} + {15'h0000, acc_ptr_step};

      // Timing of the access in flight
      if (r.state == ST_BUSY)
      begin
         if (r.wait_cnt != NO_WAIT)
         begin
            next_r.wait_cnt = r.wait_cnt - 2'h1;
         end
         else
         begin
            next_r.state = ST_IDLE;
         end
      end

      // Register port; clear applies before new events so a set wins
      if (reg_wr)
      begin
         case (reg_addr)
            REG_READ_PAGE: next_r.read_page = reg_wdata[RPAGE_W-1:0];
            REG_WRITE_PAGE: next_r.write_page = reg_wdata[PAGE_W-1:0];
            REG_CLEAR: next_r.status = r.status & ~reg_wdata[ST_W-1:0];
            REG_ENABLE: next_r.enable = reg_wdata[ST_W-1:0];
            default: next_r.status = next_r.status;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            REG_READ_PAGE: next_r.rdata = {6'h00, r.read_page};
            REG_WRITE_PAGE: next_r.rdata = {7'h00, r.write_page};
            REG_STATUS: next_r.rdata = {14'h0000, r.status};
            REG_ENABLE: next_r.rdata = {14'h0000, r.enable};
            default: next_r.rdata = '0;
         endcase
      end

      // New access
      if (take)
      begin
         next_r.state = ST_BUSY;
         next_r.write = acc_write && !acc_rmw;
         next_r.addr = sel_addr;
         next_r.in_repeat = acc_repeat;

         if (!window)
         begin
            next_r.target = TGT_LOWER; // R16
         end
         else if (program_view)
         begin
            next_r.target = TGT_PROGRAM; // R17
         end
         else if (sel_page <= INTERNAL_PAGE_LAST)
         begin
            next_r.target = TGT_INTERNAL; // R15
         end
         else
         begin
            next_r.target = TGT_PMP; // R15
         end

         // Page zero duplicates base memory, so it is refused
         if (window && zero_page && !program_view)
         begin
            next_r.trap = 1'b1; // R6
            next_r.status[ST_TRAP_BIT] = 1'b1; // R6
         end
         else
         begin
            next_r.strobe = 1'b1;
         end

         // Only extended reads pay the extra cycle; repeats pay it once
         if (window && use_read_page && !(acc_repeat && r.in_repeat))
         begin
            next_r.wait_cnt = READ_EXTRA_WAIT; // R9 R10
         end
         else
         begin
            next_r.wait_cnt = NO_WAIT; // R11 R10
         end

         // Pointer update; page registers are never touched here
         if (acc_ptr_inc && window && ptr_sum[EA_W])
         begin
            next_r.next_ptr = WINDOW_BASE | {1'b0, ptr_sum[OFFSET_W-1:0]}; // R18 R7
            next_r.status[ST_WRAP_BIT] = 1'b1;
         end
         else if (acc_ptr_inc)
         begin
            next_r.next_ptr = ptr_sum[EA_W-1:0];
         end
         else
         begin
            next_r.next_ptr = acc_ea;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         r <= CORE_RESET;
      end
      else if (clock_enable)
      begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_comb
   begin
      acc_done = (r.state == ST_BUSY) && (r.wait_cnt == NO_WAIT);
      acc_ready = (r.state == ST_IDLE) || acc_done;
      irq = |(r.status & r.enable);
      reg_rdata = r.rdata;
      next_pointer = r.next_ptr;
      mem_strobe = r.strobe;
      mem_write = r.write;
      mem_addr = r.addr;
      mem_target = r.target;
      addr_error_trap = r.trap;
   end

endmodule

// ===== verification/eds_paging_chk_sva.sv
// Purpose: Port assertions for extended window paging
// Assumes: clock_enable stays high while an access runs
// Notes: Pages are internal, so only page-free relations are checked
`timescale 1ns/1ps
module paging_chk
   import window_paging_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_enable,
   input wire logic acc_req,
   input wire logic acc_write,
   input wire logic acc_rmw,
   input wire logic acc_repeat,
   input wire logic acc_ptr_inc,
   input wire logic [1:0] acc_ptr_step,
   input wire logic [EA_W-1:0] acc_ea,
   input wire logic acc_ready,
   input wire logic acc_done,
   input wire logic [EA_W-1:0] next_pointer,
   input wire logic mem_strobe,
   input wire logic mem_write,
   input wire logic [XA_W-1:0] mem_addr,
   input wire logic [1:0] mem_target,
   input wire logic addr_error_trap
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire take = acc_req && acc_ready && clock_enable;
   a_low_direct: assert property (
      take && !acc_ea[15] ##1 mem_strobe |-> mem_addr == {8'h00, $past(acc_ea)})
      else $error("lower address wrong");
   a_offset_kept: assert property (
      take && acc_ea[15] ##1 mem_strobe |->
      {1'b0, mem_addr[14:0]} == ($past(acc_ea) & 16'h7FFF)) else $error("offset lost");
   a_read_extra: assert property (
      take && acc_ea[15] && (!acc_write || acc_rmw) && !acc_repeat ##1 mem_strobe
      |-> !acc_done && !acc_ready ##1 acc_done) else $error("read wait wrong");
   a_write_single: assert property (
      take && acc_write && !acc_rmw ##1 mem_strobe |-> acc_done && mem_write)
      else $error("write not single cycle");
   a_rmw_read: assert property (take && acc_rmw |=> !mem_write)
      else $error("rmw marked as write");
   a_trap_cause: assert property (
      addr_error_trap |-> !mem_strobe && $past(take) && $past(acc_ea) >= WINDOW_BASE)
      else $error("trap without window access");
   a_strobe_take: assert property (mem_strobe |-> $past(take))
      else $error("strobe without request");
   a_ptr_wrap: assert property (
      take && acc_ea[15] && acc_ptr_inc |=>
      next_pointer == (($past(acc_ea) + $past(acc_ptr_step)) | WINDOW_BASE))
      else $error("pointer left window");
   a_view_read: assert property (
      mem_strobe && mem_target == TGT_PROGRAM |-> !mem_write) else $error("program write");
   c_trap: cover property (addr_error_trap);
   c_wrap: cover property (take && acc_ptr_inc && acc_ea == 16'hFFFF);
   c_view: cover property (mem_strobe && mem_target == TGT_PROGRAM);
endmodule
bind extended_data_space_paging paging_chk i_chk (
   .clock(clock), .rst(rst), .clock_enable(clock_enable), .acc_req(acc_req),
   .acc_write(acc_write), .acc_rmw(acc_rmw), .acc_repeat(acc_repeat),
   .acc_ptr_inc(acc_ptr_inc), .acc_ptr_step(acc_ptr_step), .acc_ea(acc_ea),
   .acc_ready(acc_ready), .acc_done(acc_done), .next_pointer(next_pointer),
   .mem_strobe(mem_strobe), .mem_write(mem_write), .mem_addr(mem_addr),
   .mem_target(mem_target), .addr_error_trap(addr_error_trap));

// ===== verification/eds_core_model.sv
// Purpose: Core side model issuing data accesses
// Assumes: Requests held until taken, next one on the done cycle
// Notes: Kind bits are write, rmw, repeat, post-increment, step
`timescale 1ns/1ps
module core_access_model
   import window_paging_pkg::*;
(
   input wire logic clock,
   input wire logic acc_ready,
   input wire logic acc_done,
   output logic acc_req,
   output logic acc_write,
   output logic acc_rmw,
   output logic acc_repeat,
   output logic acc_ptr_inc,
   output logic [1:0] acc_ptr_step,
   output logic [EA_W-1:0] acc_ea
);
   int lat [4];
   initial
   begin
      {acc_req, acc_write, acc_rmw, acc_repeat, acc_ptr_inc, acc_ptr_step} = '0;
      acc_ea = 16'h5A5A;
   end
   task automatic access(input logic [5:0] k, input logic [EA_W-1:0] ea, input int n);
      int c;
      @(posedge clock);
      acc_req <= 1'b1;
      acc_ea <= ea;
      {acc_write, acc_rmw, acc_repeat, acc_ptr_inc, acc_ptr_step} <= k;
      for (int i = 0; i < n; i++)
      begin
         c = 0;
         #1;
         while (acc_ready !== 1'b1 && c < 20)
         begin
            @(posedge clock);
            #1;
            c++;
         end
         @(posedge clock);
         if (i == n - 1)
         begin
            acc_req <= 1'b0;
            // Released address is inverted so a stale value cannot pass
            acc_ea <= ~ea;
         end
         c = 1;
         #1;
         while (acc_done !== 1'b1 && c < 20)
         begin
            @(posedge clock);
            #1;
            c++;
         end
         lat[i] = c;
      end
   endtask
endmodule

// ===== verification/test_extended_data_space_paging.sv
// Purpose: Self-checking bench for extended window paging
// Assumes: Core model drives accesses, bench owns the register port
// Notes: Trap pulses are judged directly and through sticky status and irq
`timescale 1ns/1ps
module test_extended_data_space_paging
   import window_paging_pkg::*;
;
   localparam logic [5:0] K_RD = 6'h00;
   localparam logic [5:0] K_WR = 6'h20;
   localparam logic [5:0] K_RMW = 6'h30;
   localparam logic [5:0] K_REP = 6'h08;
   localparam logic [5:0] K_INC = 6'h05;
   logic clock, rst, clock_enable, reg_wr, reg_rd, irq;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, acc_ea, next_pointer;
   logic acc_req, acc_write, acc_rmw, acc_repeat, acc_ptr_inc, acc_ready, acc_done;
   logic [1:0] acc_ptr_step, mem_target;
   logic mem_strobe, mem_write, addr_error_trap;
   logic [23:0] mem_addr;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   extended_data_space_paging i_dut (
      .clock(clock), .rst(rst), .clock_enable(clock_enable), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .acc_req(acc_req), .acc_write(acc_write), .acc_rmw(acc_rmw),
      .acc_repeat(acc_repeat), .acc_ptr_inc(acc_ptr_inc), .acc_ptr_step(acc_ptr_step),
      .acc_ea(acc_ea), .acc_ready(acc_ready), .acc_done(acc_done),
      .next_pointer(next_pointer), .mem_strobe(mem_strobe), .mem_write(mem_write),
      .mem_addr(mem_addr), .mem_target(mem_target), .addr_error_trap(addr_error_trap),
      .irq(irq));
   core_access_model i_core (
      .clock(clock), .acc_ready(acc_ready), .acc_done(acc_done), .acc_req(acc_req),
      .acc_write(acc_write), .acc_rmw(acc_rmw), .acc_repeat(acc_repeat),
      .acc_ptr_inc(acc_ptr_inc), .acc_ptr_step(acc_ptr_step), .acc_ea(acc_ea));
   initial
   begin
      clock = 0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         bad_count++;
         results();
      end
   end
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clock);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk("reg", reg_rdata, e);
   endtask
   task automatic t_reset;
      rd(8'h00, 16'h0001);
      rd(8'h04, 16'h0001);
      rd(8'h08, 16'h0000);
      rd(8'h0C, 16'h0000);
      rd(8'h14, 16'h0000);
      $display("reset values done");
   endtask
   task automatic t_paths;
      wr(8'h00, 16'h0003);
      wr(8'h04, 16'h0002);
      i_core.access(K_WR, 16'h8800, 1);
      chk("wr addr", mem_addr, 24'h01_0800);
      chk("wr target", mem_target, TGT_PMP);
      chk("wr strobe", {mem_strobe, mem_write}, 2'h3);
      chk("wr cycles", i_core.lat[0], 2'h1);
      i_core.access(K_RD, 16'h8800, 1);
      chk("rd addr", mem_addr, 24'h01_8800);
      chk("rd cycles", i_core.lat[0], 2'h2);
      i_core.access(K_RMW, 16'h8010, 1);
      chk("rmw addr", mem_addr, 24'h01_8010);
      chk("rmw write", mem_write, 1'b0);
      i_core.access(K_RD, 16'h1234, 1);
      chk("low addr", mem_addr, 24'h00_1234);
      chk("low target", mem_target, TGT_LOWER);
      $display("address paths done");
   endtask
   task automatic t_view;
      wr(8'h00, 16'h0205);
      wr(8'h04, 16'h0000);
      i_core.access(K_RD, 16'h8800, 1);
      chk("view addr", mem_addr, 24'h02_8800);
      chk("view target", mem_target, TGT_PROGRAM);
      rd(8'h08, 16'h0000);
      $display("program view done");
   endtask
   task automatic t_trap;
      i_core.access(K_WR, 16'h8000, 1);
      chk("trap pulse", {addr_error_trap, mem_strobe}, 2'h2);
      rd(8'h08, 16'h0001);
      chk("irq masked", irq, 1'b0);
      wr(8'h10, 16'h0003);
      #1;
      chk("irq set", irq, 1'b1);
      wr(8'h0C, 16'h0001);
      #1;
      chk("irq clear", irq, 1'b0);
      wr(8'h00, 16'h0000);
      i_core.access(K_RD, 16'h9000, 1);
      rd(8'h08, 16'h0001);
      wr(8'h0C, 16'h0001);
      $display("page zero trap done");
   endtask
   task automatic t_wrap;
      wr(8'h00, 16'h0003);
      i_core.access(K_INC, 16'hFFFF, 1);
      chk("wrap ptr", next_pointer, 16'h8000);
      rd(8'h08, 16'h0002);
      chk("wrap irq", irq, 1'b1);
      rd(8'h00, 16'h0003);
      wr(8'h0C, 16'h0002);
      wr(8'h00, 16'h0004);
      @(posedge clock);
      clock_enable <= 1'b0;
      wr(8'h00, 16'h0009);
      clock_enable <= 1'b1;
      rd(8'h00, 16'h0004);
      $display("pointer wrap done");
   endtask
   task automatic t_repeat;
      i_core.access(K_REP, 16'h8000, 3);
      chk("rep first", i_core.lat[0], 2'h2);
      chk("rep second", i_core.lat[1], 2'h1);
      chk("rep third", i_core.lat[2], 2'h1);
      $display("repeat reads done");
   endtask
   initial
   begin
      {clock_enable, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      rst = 1'b1;
      clock_enable = 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_paths();
      t_view();
      t_trap();
      t_wrap();
      t_repeat();
      results();
   end
endmodule
